// *** logic/nbs_pkg.sv ***
// constants, register map and state codes of the nine-bit serial port
package nbs_pkg;
    // register byte addresses on the avalon bus
    localparam logic [7:0] SERIAL_CONTROL_STATUS_ADDR = 8'h98;
    localparam logic [7:0] SERIAL_BUFFER_ADDR = 8'h9c;
    localparam logic [7:0] PWR_ADDR = 8'ha0;
    localparam logic [7:0] RELOAD_ADDR = 8'ha4;
    localparam logic [7:0] TCTL_ADDR = 8'ha8;

    // serial_control_status field positions
    localparam int SC_TOP = 7;
    localparam int SC_MODE_LO = 6;
    localparam int SC_FILTER = 5;
    localparam int SC_RX_EN = 4;
    localparam int SC_TX9 = 3;
    localparam int SC_RX9 = 2;
    localparam int SC_TX_DONE = 1;
    localparam int SC_RX_DONE = 0;

    // power_control_reg field positions
    localparam int PC_DOUBLE = 7;
    localparam int PC_VIEW = 6;

    // timer control field positions
    localparam int TC_RUN = 0;
    localparam int TC_OVF = 1;

    // reset values
    localparam logic [7:0] SERIAL_CONTROL_STATUS_RST = 8'h00;
    localparam logic [7:0] PWR_RST = 8'h00;
    localparam logic [7:0] RELOAD_RST = 8'h00;
    localparam logic [1:0] TCTL_RST = 2'h0;

    // timing counts: divider in clock cycles, divide-by-16 and sample counts in 16x ticks; shift patterns
    localparam int MC_DIV = 6;
    localparam logic [3:0] DIV16_LAST = 4'hf;
    localparam logic [3:0] SAMPLE_A = 4'h7;
    localparam logic [3:0] SAMPLE_B = 4'h8;
    localparam logic [3:0] SAMPLE_C = 4'h9;
    localparam logic [8:0] RX_PRELOAD = 9'h1ff;
    localparam logic [7:0] TX_END_MARK = 8'h01;

    typedef enum logic [1:0] {
        MODE_SHIFT = 2'h0,
        MODE_8_VAR = 2'h1,
        MODE_9_FIX = 2'h2,
        MODE_9_VAR = 2'h3
    } nbs_mode_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'h1,
        TX_START = 3'h2,
        TX_DATA = 3'h4
    } nbs_tx_state_t;

    typedef enum logic [2:0] {
        RX_IDLE = 3'h1,
        RX_BITS = 3'h2,
        RX_STOP = 3'h4
    } nbs_rx_state_t;
endpackage

// *** logic/nbs_serial_port.sv ***
// nine-bit serial port with baud timer and avalon register slave
//
// Overview of operation
// - bit 7 of control shows framing error when view select set, else mode_hi
// - framing error set on missing stop bit, sticky until software clears it
// - two mode bits pick shift, 8-bit variable, 9-bit fixed, 9-bit variable
// - shift register mode runs at clock divided by six
// - fixed 9-bit mode runs at clock/32, or clock/16 with doubling
// - variable modes follow timer overflow: clock/192 or /96 over 256-reload
// - 9-bit frame: start low, eight data lsb first, ninth bit, stop high
// - buffer write loads shifter with ninth bit in 9-bit modes, a one otherwise, and requests a transmission
// - transmission starts after next divide-by-16 rollover (next machine tick in shift mode), not at the write
// - start, data enable, 9-bit modes shift fill one then zeros, other modes zeros only, done flag at end
// - receive samples at 16x; falling edge resets counter, preloads all ones
// - each bit sampled at counts 7, 8, 9; majority value taken
// - start bit not zero resets receiver to wait for a falling edge
// - start bit at rightmost place (bit 0): final shift, load buffer, set rx done
// - load only if rx done clear and filter off or ninth bit one
// - one bit time after final shift receiver watches for falling edge
// - filter ignored in shift mode; in 8-bit mode filter on needs valid stop bit
// - 9-bit receive equals 8-bit receive; transmit adds ninth position
// - framing errors are visible through the framing error flag
// - timer overflow sets its flag and reloads low byte from reload value
`timescale 1ns/1ps
module nbs_serial_port
    import nbs_pkg::*;
#(
    parameter int MC_DIV_P = MC_DIV
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [7:0] avm_address_i,
    input wire logic avm_read_i,
    input wire logic avm_write_i,
    input wire logic [31:0] avm_writedata_i,
    input wire logic [3:0] avm_byteenable_i,
    output logic [31:0] avm_readdata_o,
    output logic avm_waitrequest_o,
    input wire logic rxd_i,
    output logic txd_o
);
    localparam int MCW = $clog2(MC_DIV_P);
    localparam logic [MCW-1:0] MC_LAST = MCW'(MC_DIV_P - 1);

    generate
        if (MC_DIV_P < 2) begin : g_bad_div
            $error("machine cycle divider must be at least 2");
        end
    endgenerate

    function automatic logic maj3(input logic a, input logic b,
                                  input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // reset release
    logic [1:0] rst_sync;
    logic rst_n;
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    ////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle, then the answer
    logic ack;
    logic wr_en;
    logic wr_serial_control_status, wr_serial_buffer, wr_pwr, wr_reload, wr_tctl;
    logic [7:0] wd;
    logic [31:0] rd_mux;

    assign avm_waitrequest_o = (avm_read_i | avm_write_i) & ~ack;
    assign wr_en = avm_write_i & ack & avm_byteenable_i[0];
    assign wd = avm_writedata_i[7:0];
    assign wr_serial_control_status = wr_en && (avm_address_i == SERIAL_CONTROL_STATUS_ADDR);
    assign wr_serial_buffer = wr_en && (avm_address_i == SERIAL_BUFFER_ADDR);
    assign wr_pwr = wr_en && (avm_address_i == PWR_ADDR);
    assign wr_reload = wr_en && (avm_address_i == RELOAD_ADDR);
    assign wr_tctl = wr_en && (avm_address_i == TCTL_ADDR);

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= (avm_read_i | avm_write_i) & ~ack;
        end
    end

    // control and status bits
    logic sm0, sm1, filter_en, rx_en, tx9, rx9, tx_done, rx_done, fe;
    logic baud_double, view_sel;
    logic [7:0] reload_val, timer_low;
    logic timer_run, timer_ovf;
    logic [7:0] rx_buf;
    nbs_mode_t mode;
    assign mode = nbs_mode_t'({sm0, sm1});

    always_comb begin
        rd_mux = 32'h0;
        case (avm_address_i)
            SERIAL_CONTROL_STATUS_ADDR: begin
                rd_mux[7:0] = {view_sel ? fe : sm0, sm1, filter_en,
                               rx_en, tx9, rx9, tx_done, rx_done};
            end
            SERIAL_BUFFER_ADDR: rd_mux[7:0] = rx_buf;
            PWR_ADDR: begin
                rd_mux[PC_DOUBLE] = baud_double;
                rd_mux[PC_VIEW] = view_sel;
            end
            RELOAD_ADDR: rd_mux[7:0] = reload_val;
            TCTL_ADDR: begin
                rd_mux[15:8] = timer_low;
                rd_mux[TC_OVF] = timer_ovf;
                rd_mux[TC_RUN] = timer_run;
            end
            default: rd_mux = 32'h0;
        endcase
    end

    // data settles in the wait cycle and stands at the answer edge
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            avm_readdata_o <= 32'h0;
        end else if (avm_read_i & ~ack) begin
            avm_readdata_o <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // baud timer in 8-bit auto-reload
    logic [MCW-1:0] mc_cnt;
    logic mc_tick, t_ovf;
    assign mc_tick = (mc_cnt == MC_LAST);
    assign t_ovf = timer_run & mc_tick & (timer_low == 8'hff);

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            mc_cnt <= '0;
        end else begin
            mc_cnt <= mc_tick ? '0 : mc_cnt + MCW'(1);
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            timer_low <= RELOAD_RST;
            reload_val <= RELOAD_RST;
            {timer_ovf, timer_run} <= TCTL_RST;
        end else begin
            if (wr_reload) begin
                reload_val <= wd;
            end
            if (timer_run && mc_tick) begin
                timer_low <= t_ovf ? reload_val : timer_low + 8'h1;
            end
            if (wr_tctl) begin
                timer_run <= wd[TC_RUN];
            end
            // set wins over a software clear
            if (t_ovf) begin
                timer_ovf <= 1'b1;
            end else if (wr_tctl) begin
                timer_ovf <= timer_ovf & wd[TC_OVF];
            end
        end
    end

    // 16x sample tick; without doubling every second source pulse
    logic tick_src, half, tick16;
    assign tick_src = (mode == MODE_9_FIX) ? 1'b1 : t_ovf;
    assign tick16 = tick_src & (baud_double | half);

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            half <= 1'b0;
        end else if (tick_src) begin
            half <= ~half;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmitter
    logic [3:0] tx_div;
    logic tx_roll, tx_bit, tx_req, tx_fill, tx_done_p;
    logic [8:0] tx_sr;
    nbs_tx_state_t tx_state;
    assign tx_roll = tick16 & (tx_div == DIV16_LAST);
    assign tx_bit = (mode == MODE_SHIFT) ? mc_tick : tx_roll;

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_div <= 4'h0;
        end else if (tick16) begin
            tx_div <= tx_div + 4'h1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_state <= TX_IDLE;
            tx_sr <= 9'h0;
            tx_fill <= 1'b0;
            tx_req <= 1'b0;
            tx_done_p <= 1'b0;
            txd_o <= 1'b1;
        end else begin
            tx_done_p <= 1'b0;
            if (wr_serial_buffer) begin
                // 8-bit frame puts the stop bit straight in position nine
                tx_sr <= {mode[1] ? tx9 : 1'b1, wd};
                tx_fill <= mode[1];
                tx_req <= 1'b1;
            end
            case (tx_state)
                TX_IDLE: begin
                    txd_o <= 1'b1;
                    if (tx_req && tx_bit && !wr_serial_buffer) begin
                        tx_req <= 1'b0;
                        if (mode == MODE_SHIFT) begin
                            tx_state <= TX_DATA;
                            txd_o <= tx_sr[0];
                        end else begin
                            tx_state <= TX_START;
                            txd_o <= 1'b0;
                        end
                    end
                end
                TX_START: begin
                    if (tx_bit) begin
                        tx_state <= TX_DATA;
                        txd_o <= tx_sr[0];
                    end
                end
                TX_DATA: begin
                    if (tx_bit && !wr_serial_buffer) begin
                        // fill one still pending: pattern is data, not end
                        if (tx_sr[8:1] == TX_END_MARK && !tx_fill) begin
                            tx_state <= TX_IDLE;
                            txd_o <= 1'b1;
                            tx_done_p <= 1'b1;
                        end else begin
                            tx_sr <= {tx_fill, tx_sr[8:1]};
                            tx_fill <= 1'b0;
                            txd_o <= tx_sr[1];
                        end
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // receiver
    logic [2:0] rx_s;
    logic rx_f, rx_prev, fall;
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_s <= 3'h7;
            rx_f <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_s <= {rx_s[1:0], rxd_i};
            if (rx_s[1] == rx_s[2]) begin
                rx_f <= rx_s[2];
            end
            if (tick16) begin
                rx_prev <= rx_f;
            end
        end
    end
    assign fall = tick16 & rx_prev & ~rx_f;

    nbs_rx_state_t rx_state;
    logic [3:0] rx_cnt;
    logic [8:0] rx_sr;
    logic rx_first, smp_a, smp_b, rx_bitv, rx_final, rx_accept;
    logic rx_load, rx_ninth, fe_set;
    assign rx_bitv = maj3(smp_a, smp_b, rx_f);
    assign rx_final = (rx_state == RX_BITS) && tick16 &&
                      (rx_cnt == SAMPLE_C) && !rx_first && !rx_sr[0];
    // filter has no say in shift mode, where nothing is received
    assign rx_accept = rx_final && !rx_done &&
                       (!filter_en || rx_bitv);

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_state <= RX_IDLE;
            rx_cnt <= 4'h0;
            rx_sr <= RX_PRELOAD;
            rx_first <= 1'b0;
            smp_a <= 1'b1;
            smp_b <= 1'b1;
            rx_buf <= 8'h0;
            rx_ninth <= 1'b0;
            rx_load <= 1'b0;
            fe_set <= 1'b0;
        end else begin
            rx_load <= 1'b0;
            fe_set <= 1'b0;
            if (tick16 && rx_state != RX_IDLE) begin
                rx_cnt <= rx_cnt + 4'h1;
                if (rx_cnt == SAMPLE_A) begin
                    smp_a <= rx_f;
                end
                if (rx_cnt == SAMPLE_B) begin
                    smp_b <= rx_f;
                end
            end
            case (rx_state)
                RX_IDLE: begin
                    if (fall && rx_en && mode != MODE_SHIFT) begin
                        rx_cnt <= 4'h0;
                        rx_sr <= RX_PRELOAD;
                        rx_first <= 1'b1;
                        rx_state <= RX_BITS;
                    end
                end
                RX_BITS: begin
                    if (tick16 && rx_cnt == SAMPLE_C) begin
                        rx_first <= 1'b0;
                        if (rx_first && rx_bitv) begin
                            rx_state <= RX_IDLE;
                        end else begin
                            rx_sr <= {rx_bitv, rx_sr[8:1]};
                        end
                        if (rx_final) begin
                            rx_state <= RX_STOP;
                            // in 8-bit mode the last bit is the stop bit
                            fe_set <= !mode[1] && !rx_bitv;
                        end
                        if (rx_accept) begin
                            rx_buf <= rx_sr[8:1];
                            rx_ninth <= rx_bitv;
                            rx_load <= 1'b1;
                        end
                    end
                end
                RX_STOP: begin
                    if (tick16 && rx_cnt == SAMPLE_C) begin
                        fe_set <= mode[1] && !rx_bitv;
                        rx_state <= RX_IDLE;
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control register: hardware set wins over software clear
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            {sm0, sm1, filter_en, rx_en, tx9, rx9, tx_done, rx_done}
                <= SERIAL_CONTROL_STATUS_RST;
            fe <= 1'b0;
            {baud_double, view_sel} <= PWR_RST[PC_DOUBLE:PC_VIEW];
        end else begin
            if (wr_pwr) begin
                baud_double <= wd[PC_DOUBLE];
                view_sel <= wd[PC_VIEW];
            end
            if (wr_serial_control_status) begin
                if (!view_sel) begin
                    sm0 <= wd[SC_TOP];
                end
                sm1 <= wd[SC_MODE_LO];
                filter_en <= wd[SC_FILTER];
                rx_en <= wd[SC_RX_EN];
                tx9 <= wd[SC_TX9];
            end
            if (fe_set) begin
                fe <= 1'b1;
            end else if (wr_serial_control_status && view_sel) begin
                fe <= wd[SC_TOP];
            end
            if (rx_load) begin
                rx9 <= rx_ninth;
            end else if (wr_serial_control_status) begin
                rx9 <= wd[SC_RX9];
            end
            if (tx_done_p) begin
                tx_done <= 1'b1;
            end else if (wr_serial_control_status) begin
                tx_done <= wd[SC_TX_DONE];
            end
            if (rx_load) begin
                rx_done <= 1'b1;
            end else if (wr_serial_control_status) begin
                rx_done <= wd[SC_RX_DONE];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n);

    sequence s_idle_req_roll;
        tx_state == TX_IDLE && tx_req && tx_bit && !wr_serial_buffer &&
            mode != MODE_SHIFT;
    endsequence
    sequence s_start_out;
        tx_state == TX_START && txd_o == 1'b0;
    endsequence

    a_fe_sticky_hold: assert property (
        fe && !(wr_serial_control_status && view_sel && !wd[SC_TOP]) |=> fe)
        else $error("framing error flag dropped on its own");
    a_shift_rate_six: assert property (
        mc_tick |=> !mc_tick [*5] ##1 mc_tick)
        else $error("shift mode tick not every sixth cycle");
    a_fixed_rate_dbl: assert property (
        mode == MODE_9_FIX && baud_double |-> tick16)
        else $error("doubled fixed rate tick missing");
    a_fixed_rate_half: assert property (
        mode == MODE_9_FIX && !baud_double && !wr_pwr && tick16
        |=> !tick16)
        else $error("undoubled fixed rate tick not halved");
    a_tx_start_align: assert property (
        s_idle_req_roll |=> s_start_out)
        else $error("transmission did not start at rollover");
    a_rx_preload_ones: assert property (
        rx_state == RX_IDLE && fall && rx_en && mode != MODE_SHIFT
        |=> rx_sr == RX_PRELOAD && rx_cnt == 4'h0 && rx_state == RX_BITS)
        else $error("receiver not preloaded on falling edge");
    a_bad_start_drop: assert property (
        rx_state == RX_BITS && rx_first && tick16 &&
        rx_cnt == SAMPLE_C && rx_bitv |=> rx_state == RX_IDLE)
        else $error("false start bit not rejected");
    a_rx_reject_keep: assert property (
        rx_final && !rx_accept |=> $stable(rx_buf) ##1 !$rose(rx_done))
        else $error("rejected frame reached the buffer");
    a_rx_done_sticky: assert property (
        rx_done && !(wr_serial_control_status && !wd[SC_RX_DONE]) |=> rx_done)
        else $error("rx done flag cleared by hardware");
    a_timer_reload_val: assert property (
        t_ovf && !wr_reload |=> timer_low == $past(reload_val) &&
        timer_ovf)
        else $error("timer overflow did not reload");
endmodule

// *** verification/nbs_remote_node.sv ***
// remote uart node model on the far side of the serial line
`timescale 1ns/1ps
module nbs_remote_node (
    input wire logic clock_i,
    input wire logic txd_i,
    output logic rxd_o
);
    // line idles high between frames
    initial rxd_o = 1'b1;

    task automatic send_frame(input int bit_clk, input logic [7:0] data,
                              input logic ninth, input logic stop);
        logic [10:0] frame;
        frame = {stop, ninth, data, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd_o <= frame[i];
            repeat (bit_clk) @(posedge clock_i);
        end
        rxd_o <= 1'b1;
        repeat (bit_clk) @(posedge clock_i);
    endtask

    // short low pulse, too brief to pass as a start bit
    task automatic pulse_low(input int len);
        rxd_o <= 1'b0;
        repeat (len) @(posedge clock_i);
        rxd_o <= 1'b1;
    endtask

    task automatic recv_frame(input int bit_clk, output logic [10:0] f,
                              output logic ok);
        int n;
        n = 0;
        while (txd_i !== 1'b0 && n < 4000) begin
            @(posedge clock_i);
            n++;
        end
        ok = (n < 4000);
        repeat (bit_clk / 2) @(posedge clock_i);
        for (int i = 0; i < 11; i++) begin
            f[i] = txd_i;
            repeat (bit_clk) @(posedge clock_i);
        end
    endtask
endmodule

// *** verification/test_nbs_serial_port.sv ***
// self-checking bench for the nine-bit serial port
`timescale 1ns/1ps
module test_nbs_serial_port;
    import nbs_pkg::*;
    logic clock_i, nrst_i, rd, wr, rxd, txd, wait_o, ok;
    logic [7:0] addr, q;
    logic [31:0] wdata, rdata;
    logic [3:0] be;
    logic [10:0] f;
    int bad_count, check_count;

    nbs_serial_port #(.MC_DIV_P(MC_DIV)) DUT (
        .clock_i(clock_i), .nrst_i(nrst_i), .avm_address_i(addr),
        .avm_read_i(rd), .avm_write_i(wr), .avm_writedata_i(wdata),
        .avm_byteenable_i(be), .avm_readdata_o(rdata),
        .avm_waitrequest_o(wait_o), .rxd_i(rxd), .txd_o(txd));
    nbs_remote_node node (.clock_i(clock_i), .txd_i(txd), .rxd_o(rxd));

    ////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // waitrequest and read data are taken at the rising edge itself
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        logic busy;
        int n;
        n = 0;
        addr <= a;
        wdata <= {24'h0, d};
        rd <= !w;
        wr <= w;
        do begin
            @(posedge clock_i);
            busy = (wait_o !== 1'b0);
            q = rdata[7:0];
            n++;
        end while (busy && n < 50);
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clock_i);
        if (busy) begin
            bad_count++;
            close_out();
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        bus(0, SERIAL_CONTROL_STATUS_ADDR, 8'h00);
        check("serial_control_status reset", 8'h00, q);
        bus(0, PWR_ADDR, 8'h00);
        check("power reset", 8'h00, q);
        bus(0, RELOAD_ADDR, 8'h00);
        check("reload reset", 8'h00, q);
        bus(1, 8'h94, 8'h5f);
        bus(0, 8'h94, 8'h00);
        check("unmapped", 8'h00, q);
    endtask

    // shift mode: eight bits at a sixth of the clock, no start bit
    task automatic t_shift();
        bus(1, SERIAL_CONTROL_STATUS_ADDR, 8'h00);
        fork
            bus(1, SERIAL_BUFFER_ADDR, 8'h5a);
            node.recv_frame(MC_DIV, f, ok);
        join
        check("shift seen", 8'h01, {7'h0, ok});
        check("shift data", 8'h5a, f[7:0]);
        bus(0, SERIAL_CONTROL_STATUS_ADDR, 8'h00);
        check("shift done", 8'h02, q);
        bus(1, SERIAL_CONTROL_STATUS_ADDR, 8'h00);
    endtask

    // fixed rate undoubled and doubled, then timer rate with reload ff
    // in 9-bit and 8-bit frames; 8-bit stop lands where the ninth is
    task automatic t_tx();
        logic [7:0] pw[4] = '{8'h00, 8'h80, 8'h80, 8'h80};
        logic [7:0] sc[4] = '{8'h98, 8'h90, 8'hd8, 8'h58};
        logic [7:0] dat[4] = '{8'ha5, 8'h02, 8'h81, 8'h40};
        int bc[4] = '{32, 16, 96, 96};
        for (int i = 0; i < 4; i++) begin
            bus(1, PWR_ADDR, pw[i]);
            bus(1, RELOAD_ADDR, 8'hff);
            bus(1, TCTL_ADDR, 8'h01);
            bus(1, SERIAL_CONTROL_STATUS_ADDR, sc[i]);
            fork
                bus(1, SERIAL_BUFFER_ADDR, dat[i]);
                node.recv_frame(bc[i], f, ok);
            join
            check("tx seen", 8'h01, {7'h0, ok});
            check("tx start", 8'h00, {7'h0, f[0]});
            check("tx data", dat[i], f[8:1]);
            check("tx ninth", {7'h0, sc[i][SC_TX9]}, {7'h0, f[9]});
            check("tx stop", 8'h01, {7'h0, f[10]});
            bus(0, SERIAL_CONTROL_STATUS_ADDR, 8'h00);
            check("tx done", sc[i] | 8'h02, q);
            bus(1, SERIAL_CONTROL_STATUS_ADDR, sc[i] & 8'hf7);
        end
        bus(0, TCTL_ADDR, 8'h00);
        check("timer ovf", 8'h02, q & 8'h02);
    endtask

    task automatic rx_frame(input logic [7:0] d, input logic n9,
                            input logic stop, input logic [7:0] exp_buf,
                            input logic [7:0] exp_sc);
        node.send_frame(16, d, n9, stop);
        bus(0, SERIAL_BUFFER_ADDR, 8'h00);
        check("rx buffer", exp_buf, q);
        bus(0, SERIAL_CONTROL_STATUS_ADDR, 8'h00);
        check("rx status", exp_sc, q);
    endtask

    task automatic t_rx();
        bus(1, PWR_ADDR, 8'h80);
        bus(1, SERIAL_CONTROL_STATUS_ADDR, 8'h90);
        rx_frame(8'h5a, 1, 1, 8'h5a, 8'h95);
        rx_frame(8'hc3, 0, 1, 8'h5a, 8'h95);
        bus(1, SERIAL_CONTROL_STATUS_ADDR, 8'hb0);
        rx_frame(8'h11, 0, 1, 8'h5a, 8'hb0);
        rx_frame(8'h22, 1, 1, 8'h22, 8'hb5);
    endtask

    task automatic t_frame_err();
        bus(1, SERIAL_CONTROL_STATUS_ADDR, 8'h90);
        bus(1, PWR_ADDR, 8'hc0);
        rx_frame(8'h77, 1, 0, 8'h77, 8'h95);
        bus(1, SERIAL_CONTROL_STATUS_ADDR, 8'h90);
        rx_frame(8'h12, 1, 1, 8'h12, 8'h95);
        bus(1, SERIAL_CONTROL_STATUS_ADDR, 8'h10);
        bus(0, SERIAL_CONTROL_STATUS_ADDR, 8'h00);
        check("error cleared", 8'h00, q & 8'h80);
        bus(1, PWR_ADDR, 8'h80);
        bus(0, SERIAL_CONTROL_STATUS_ADDR, 8'h00);
        check("mode view", 8'h80, q & 8'h80);
    endtask

    // a runt low pulse must not start a frame
    task automatic t_runt();
        bus(1, SERIAL_CONTROL_STATUS_ADDR, 8'h90);
        node.pulse_low(3);
        repeat (64) @(posedge clock_i);
        bus(0, SERIAL_CONTROL_STATUS_ADDR, 8'h00);
        check("runt ignored", 8'h90, q);
        rx_frame(8'h69, 1, 1, 8'h69, 8'h95);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    initial begin
        nrst_i = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        be = 4'hf;
        bad_count = 0;
        check_count = 0;
        repeat (8) @(posedge clock_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        t_reset();
        t_shift();
        t_tx();
        t_rx();
        t_frame_err();
        t_runt();
        close_out();
    end
endmodule
